//--- rtl/gpio_summary_map.svh
// register offsets, field positions, codes and reset values of the block
`ifndef GPIO_SUMMARY_MAP_SVH
`define GPIO_SUMMARY_MAP_SVH

`define ADDR_W              8
`define DATA_W              16

`define OFF_PIN_FUNC_SEL    8'h0a
`define OFF_IRQ_SUM_STATUS  8'h10
`define OFF_IRQ_SUM_ENABLE  8'h12
`define OFF_GLOBAL_LIVE     8'h14
`define OFF_GLOBAL_CTRL     8'h20
`define OFF_EVENT_STATUS    8'h22
`define OFF_EVENT_MASK      8'h24

`define RST_PIN_FUNC_SEL    16'h0000
`define RST_IRQ_SUM_ENABLE  16'h0000
`define RST_GLOBAL_CTRL     16'h0000
`define RST_EVENT_STATUS    2'h0
`define RST_EVENT_MASK      2'h0

`define BIT_PORT_SUMMARY    4
`define BIT_GLOBAL_SUMMARY  0
`define BIT_PLL_LOCK_LOST   1
`define BIT_PERF_DONE       0

`define CTRL_REF_SEL_LSB    1
`define CTRL_REF_SEL_MSB    3
`define CTRL_PM_MODE_LSB    4
`define CTRL_PM_MODE_MSB    5
`define CTRL_ERR_SRC        6
`define CTRL_REF8K_IN       8
`define CTRL_REF8K_OUT      9
`define CTRL_WMASK          16'h037e

`define PIN_SEL_INPUT       2'h0
`define PIN_SEL_STATUS      2'h1
`define PIN_SEL_LOW         2'h2
`define PIN_SEL_HIGH        2'h3
`define PM_MODE_PIN         2'h1

`define REF_CODE_44M736     3'h0
`define REF_CODE_34M368     3'h1
`define REF_CODE_51M84      3'h2
`define REF_CODE_19M44      3'h3
`define REF_CODE_77M76      3'h4

`define N_PINS              8
`define N_PLLS              2

`endif

//--- rtl/gpio_summary_pkg.sv
// types and shared decoding for the global pin and summary block
package gpio_summary_pkg;
`include "gpio_summary_map.svh"

   typedef logic [1:0] pin_sel_t;

   typedef enum logic [2:0] {
      REF_44M736,
      REF_34M368,
      REF_51M84,
      REF_19M44,
      REF_77M76,
      REF_UNDEFINED
   } ref_freq_t;

   function automatic ref_freq_t decode_ref(input logic [2:0] code);
      ref_freq_t f;
      f = REF_UNDEFINED;
      case (code)
         `REF_CODE_44M736: f = REF_44M736;
         `REF_CODE_34M368: f = REF_34M368;
         `REF_CODE_51M84:  f = REF_51M84;
         `REF_CODE_19M44:  f = REF_19M44;
         `REF_CODE_77M76:  f = REF_77M76;
         default:          f = REF_UNDEFINED;
      endcase
      return f;
   endfunction

   function automatic pin_sel_t pin_sel(input logic [15:0] reg_val,
                                        input int          pin);
      return reg_val[2*pin +: 2];
   endfunction
endpackage

//--- rtl/gpio_core_if.sv
// signals between the top and its pin mux and summary logic
`timescale 1ns/10ps
`default_nettype none
interface gpio_core_if;
   logic [15:0] pin_sel;
   logic [1:0]  pm_mode;
   logic        err_src;
   logic        r8k_in_sel;
   logic        r8k_out_sel;
   logic        ref8k_drive;
   logic [15:0] porta_st;
   logic [15:0] portb_st;
   logic [3:0]  porta_pick;
   logic [3:0]  portb_pick;
   logic [7:0]  pin_in;
   logic [7:0]  drv_val;
   logic [7:0]  drv_oe_n;
   logic        upd_req;
   logic        err_req;
   logic        r8k_ref;
   logic        port_irq_status_reg_any;
   logic        glob_pending;
   logic        port_en;
   logic        glob_en;
   logic        port_flag;
   logic        glob_flag;
   logic        int_active;

   modport top (output pin_sel, pm_mode, err_src, r8k_in_sel, r8k_out_sel,
                ref8k_drive, porta_st, portb_st, porta_pick, portb_pick,
                pin_in, port_irq_status_reg_any, glob_pending, port_en, glob_en,
                input drv_val, drv_oe_n, upd_req, err_req, r8k_ref,
                port_flag, glob_flag, int_active);
   modport pins (input pin_sel, pm_mode, err_src, r8k_in_sel, r8k_out_sel,
                 ref8k_drive, porta_st, portb_st, porta_pick, portb_pick,
                 pin_in,
                 output drv_val, drv_oe_n, upd_req, err_req, r8k_ref);
   modport irq (input port_irq_status_reg_any, glob_pending, port_en, glob_en,
                output port_flag, glob_flag, int_active);
endinterface
`default_nettype wire

//--- rtl/gpio_pin_mux.sv
// per-pin function select with overrides from other global functions
`timescale 1ns/10ps
`default_nettype none
`include "gpio_summary_map.svh"
module gpio_pin_mux
(
   gpio_core_if.pins bus   // control in, pin drive and requests out
);
   import gpio_summary_pkg::*;

   logic pin8_taken;
   logic pin6_taken;
   logic pin4_taken;
   logic pin2_taken;

   assign pin8_taken = (bus.pm_mode == `PM_MODE_PIN);                // RULE_03
   assign pin6_taken = bus.err_src;                                  // RULE_04
   assign pin4_taken = bus.r8k_in_sel;                               // RULE_05
   assign pin2_taken = bus.r8k_out_sel;                              // RULE_06

   // taken pins stay inputs; pin 2 carries the 8 kHz output instead
   genvar p;
   generate
      for (p = 0; p < `N_PINS; p++)
      begin : g_pin
         pin_sel_t sel;
         logic     taken;
         logic     status_bit;
         always_comb
         begin
            sel        = pin_sel(bus.pin_sel, p);                    // RULE_02
            taken      = (p == 7 && pin8_taken) || (p == 5 && pin6_taken)
                         || (p == 3 && pin4_taken);
            status_bit = 1'b0;
            if (p == 0)
               status_bit = bus.porta_st[bus.porta_pick];            // RULE_07
            else if (p == 1)
               status_bit = bus.portb_st[bus.portb_pick];            // RULE_06
            bus.drv_val[p]  = 1'b0;
            bus.drv_oe_n[p] = 1'b1;
            if (p == 1 && pin2_taken)
            begin
               bus.drv_val[p]  = bus.ref8k_drive;                    // RULE_06
               bus.drv_oe_n[p] = 1'b0;
            end
            else if (!taken)
            begin
               case (sel)
                  `PIN_SEL_LOW:
                  begin
                     bus.drv_oe_n[p] = 1'b0;
                  end
                  `PIN_SEL_HIGH:
                  begin
                     bus.drv_val[p]  = 1'b1;
                     bus.drv_oe_n[p] = 1'b0;
                  end
                  `PIN_SEL_STATUS:
                  begin
                     // reserved code on pins 3 to 8 leaves the pin an input
                     if (p < 2)
                     begin
                        bus.drv_val[p]  = status_bit;
                        bus.drv_oe_n[p] = 1'b0;
                     end
                  end
                  default:
                  begin
                     bus.drv_oe_n[p] = 1'b1;
                  end
               endcase
            end
         end
      end
   endgenerate

   assign bus.upd_req = pin8_taken & bus.pin_in[7];                  // RULE_13
   assign bus.err_req = pin6_taken & bus.pin_in[5];                  // RULE_14
   // reference reads low when the pin is not selected for it
   assign bus.r8k_ref = pin4_taken & bus.pin_in[3];                  // RULE_15
endmodule // gpio_pin_mux
`default_nettype wire

//--- rtl/gpio_irq_summary.sv
// folds port and global pending status into two summary flags
`timescale 1ns/10ps
`default_nettype none
module gpio_irq_summary
(
   gpio_core_if.irq bus   // pending status and enables in, flags out
);
   import gpio_summary_pkg::*;

   assign bus.port_flag  = bus.port_irq_status_reg_any;                         // RULE_08
   assign bus.glob_flag  = bus.glob_pending;                         // RULE_09
   assign bus.int_active = (bus.port_flag & bus.port_en)             // RULE_10
                         | (bus.glob_flag & bus.glob_en);            // RULE_11
endmodule // gpio_irq_summary
`default_nettype wire

//--- rtl/global_gpio_and_interrupt_summary.sv
// global pin control, reference select and interrupt summary of the device
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_summary_map.svh"
// Overview of operation
// RULE_01 - ref select 000..100 picks reference frequency
// RULE_02 - pin code 00 input, 10 low, 11 high
// RULE_03 - pin 8 select ignored in pin update mode
// RULE_04 - pin 6 select ignored when error source set
// RULE_05 - pin 4 select ignored when 8k input set
// RULE_06 - pin 2 code 01 outputs picked port B status
// RULE_07 - pin 1 code 01 outputs picked port A status
// RULE_08 - port summary bit 4 follows any port status
// RULE_09 - global summary bit 0: latched and enabled
// RULE_10 - port summary and enable pull interrupt low
// RULE_11 - global summary and enable pull interrupt low
// RULE_12 - lock lost bit 1 high when any PLL unlocked
// RULE_13 - pin 8 level is update request in mode 01
// RULE_14 - pin 6 is error insert request when selected
// RULE_15 - pin 4 carries external 8 kHz reference
// RULE_16 - update done bit 0 ANDs enabled port updates
// RULE_17 - summary and live status bits are read-only
// RULE_18 - interrupt is OR of both, releases when clear
module global_gpio_and_interrupt_summary
(
   input  wire logic                 clk_sys_in,           // 200 MHz clock
   input  wire logic                 resetn_in,            // async reset, low
   input  wire logic [`ADDR_W-1:0]   addr_in,              // register offset
   input  wire logic [`DATA_W-1:0]   wr_data_in,           // write data
   input  wire logic                 wr_in,                // write strobe
   input  wire logic                 rd_in,                // read strobe
   output logic      [`DATA_W-1:0]   rd_data_out,          // read data, +1
   input  wire logic [`N_PINS-1:0]   gpio_in,              // pin levels in
   output logic      [`N_PINS-1:0]   gpio_out,             // pin drive value
   output logic      [`N_PINS-1:0]   gpio_oe_n_out,        // low: drive pin
   input  wire logic [15:0]          port_irq_status_in,   // port status reg
   input  wire logic [15:0]          porta_status_in,      // port A signals
   input  wire logic [15:0]          portb_status_in,      // port B signals
   input  wire logic [3:0]           porta_status_pick_in, // port A pick
   input  wire logic [3:0]           portb_status_pick_in, // port B pick
   input  wire logic                 ref8k_drive_in,       // 8 kHz out level
   input  wire logic [`N_PLLS-1:0]   pll_locked_in,        // PLL lock flags
   input  wire logic                 port_update_done_in,  // port PM done
   input  wire logic                 port_update_en_in,    // global update on
   output logic                      perf_update_req_out,  // PM update req
   output logic                      error_insert_req_out, // error insert req
   output logic                      ref8k_in_out,         // ext 8 kHz ref
   output gpio_summary_pkg::ref_freq_t ref_freq_out,       // adapter ref
   output logic                      int_n_out,            // interrupt, low
   output logic                      irq_out               // event irq, high
);
   import gpio_summary_pkg::*;

   gpio_core_if core ();

   logic [1:0]          rst_sync_r;
   logic                rst_n;
   logic [15:0]         pin_sel_r,   pin_sel_nxt;
   logic [15:0]         sum_en_r,    sum_en_nxt;
   logic [15:0]         ctrl_r,      ctrl_nxt;
   logic [1:0]          evt_r,       evt_nxt;
   logic [1:0]          evt_mask_r,  evt_mask_nxt;
   logic [1:0]          live_prev_r;
   logic [`DATA_W-1:0]  rdata_r,     rdata_nxt;
   logic [`N_PINS-1:0]  gpio_r;
   logic [`N_PINS-1:0]  gpio_oe_n_r;
   logic                upd_r;
   logic                err_r;
   logic                r8k_r;
   ref_freq_t           ref_r;
   logic                int_n_r;
   logic                irq_r;
   logic [1:0]          live;
   logic [1:0]          evt_rise;
   logic [15:0]         sum_status;
   logic [15:0]         live_status;

   // reset released through two flops, asserted without the clock
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   assign live[`BIT_PLL_LOCK_LOST] = ~&pll_locked_in;                // RULE_12
   // with one port, the AND of enabled ports is that port when enabled
   assign live[`BIT_PERF_DONE]     = port_update_done_in
                                   | ~port_update_en_in;             // RULE_16
   assign evt_rise = live & ~live_prev_r;

   assign core.pin_sel      = pin_sel_r;
   assign core.pm_mode      = ctrl_r[`CTRL_PM_MODE_MSB:`CTRL_PM_MODE_LSB];
   assign core.err_src      = ctrl_r[`CTRL_ERR_SRC];
   assign core.r8k_in_sel   = ctrl_r[`CTRL_REF8K_IN];
   assign core.r8k_out_sel  = ctrl_r[`CTRL_REF8K_OUT];
   assign core.ref8k_drive  = ref8k_drive_in;
   assign core.porta_st     = porta_status_in;
   assign core.portb_st     = portb_status_in;
   assign core.porta_pick   = porta_status_pick_in;
   assign core.portb_pick   = portb_status_pick_in;
   assign core.pin_in       = gpio_in;
   assign core.port_irq_status_reg_any = |port_irq_status_in;                   // RULE_08
   assign core.glob_pending = |(evt_r & evt_mask_r);                 // RULE_09
   assign core.port_en      = sum_en_r[`BIT_PORT_SUMMARY];
   assign core.glob_en      = sum_en_r[`BIT_GLOBAL_SUMMARY];

   gpio_pin_mux u_pins
   (
      .bus (core.pins)
   );

   gpio_irq_summary u_irq
   (
      .bus (core.irq)
   );

   always_comb
   begin
      sum_status = 16'h0000;
      sum_status[`BIT_PORT_SUMMARY]   = core.port_flag;
      sum_status[`BIT_GLOBAL_SUMMARY] = core.glob_flag;
      live_status = {14'h0000, live};
   end

   // register file: software writes steer pins, reads show live state
   always_comb
   begin
      pin_sel_nxt  = pin_sel_r;
      sum_en_nxt   = sum_en_r;
      ctrl_nxt     = ctrl_r;
      evt_mask_nxt = evt_mask_r;
      evt_nxt      = evt_r;
      rdata_nxt    = 16'h0000;
      if (wr_in)
      begin
         case (addr_in)
            `OFF_PIN_FUNC_SEL:   pin_sel_nxt  = wr_data_in;
            `OFF_IRQ_SUM_ENABLE: sum_en_nxt   = wr_data_in
                                 & ((16'h0001 << `BIT_PORT_SUMMARY)
                                 | (16'h0001 << `BIT_GLOBAL_SUMMARY));
            `OFF_GLOBAL_CTRL:    ctrl_nxt     = wr_data_in & `CTRL_WMASK;
            `OFF_EVENT_STATUS:   evt_nxt      = evt_r & ~wr_data_in[1:0];
            `OFF_EVENT_MASK:     evt_mask_nxt = wr_data_in[1:0];
            // summary and live status ignore writes
            default:             rdata_nxt    = 16'h0000;            // RULE_17
         endcase
      end
      // a new event wins over a clear in the same cycle
      evt_nxt = evt_nxt | evt_rise;
      if (rd_in)
      begin
         case (addr_in)
            `OFF_PIN_FUNC_SEL:   rdata_nxt = pin_sel_r;
            `OFF_IRQ_SUM_STATUS: rdata_nxt = sum_status;             // RULE_17
            `OFF_IRQ_SUM_ENABLE: rdata_nxt = sum_en_r;
            `OFF_GLOBAL_LIVE:    rdata_nxt = live_status;            // RULE_12
            `OFF_GLOBAL_CTRL:    rdata_nxt = ctrl_r;
            `OFF_EVENT_STATUS:   rdata_nxt = {14'h0000, evt_r};
            `OFF_EVENT_MASK:     rdata_nxt = {14'h0000, evt_mask_r};
            default:             rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_sel_r   <= `RST_PIN_FUNC_SEL;
         sum_en_r    <= `RST_IRQ_SUM_ENABLE;
         ctrl_r      <= `RST_GLOBAL_CTRL;
         evt_r       <= `RST_EVENT_STATUS;
         evt_mask_r  <= `RST_EVENT_MASK;
         live_prev_r <= 2'h3;   // no false rise at reset
         rdata_r     <= 16'h0000;
      end
      else
      begin
         pin_sel_r   <= pin_sel_nxt;
         sum_en_r    <= sum_en_nxt;
         ctrl_r      <= ctrl_nxt;
         evt_r       <= evt_nxt;
         evt_mask_r  <= evt_mask_nxt;
         live_prev_r <= live;
         rdata_r     <= rdata_nxt;
      end
   end

   // every top output registered; one cycle from core logic to pin, two from a register write
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gpio_r      <= 8'h00;
         gpio_oe_n_r <= 8'hff;
         upd_r       <= 1'b0;
         err_r       <= 1'b0;
         r8k_r       <= 1'b0;
         ref_r       <= REF_44M736;
         int_n_r     <= 1'b1;
         irq_r       <= 1'b0;
      end
      else
      begin
         gpio_r      <= core.drv_val;                                // RULE_02
         gpio_oe_n_r <= core.drv_oe_n;
         upd_r       <= core.upd_req;                                // RULE_13
         err_r       <= core.err_req;                                // RULE_14
         r8k_r       <= core.r8k_ref;                                // RULE_15
         ref_r       <= decode_ref(ctrl_r[`CTRL_REF_SEL_MSB:
                                          `CTRL_REF_SEL_LSB]);       // RULE_01
         int_n_r     <= ~core.int_active;                            // RULE_18
         irq_r       <= |(evt_r & evt_mask_r);
      end
   end

   assign rd_data_out          = rdata_r;
   assign gpio_out             = gpio_r;
   assign gpio_oe_n_out        = gpio_oe_n_r;
   assign perf_update_req_out  = upd_r;
   assign error_insert_req_out = err_r;
   assign ref8k_in_out         = r8k_r;
   assign ref_freq_out         = ref_r;
   assign int_n_out            = int_n_r;
   assign irq_out              = irq_r;
endmodule // global_gpio_and_interrupt_summary
`default_nettype wire

//--- tb/gpio_summary_sva.sv
// assertion checker for the global pin and summary block
`timescale 1ns/10ps
`default_nettype none
`include "gpio_summary_map.svh"
module gpio_summary_sva
   import gpio_summary_pkg::*;
(
   input wire logic                 clk_sys_in,
   input wire logic                 resetn_in,
   input wire logic [`ADDR_W-1:0]   addr_in,
   input wire logic [`DATA_W-1:0]   wr_data_in,
   input wire logic                 wr_in,
   input wire logic [`N_PINS-1:0]   gpio_in,
   input wire logic [`N_PINS-1:0]   gpio_out,
   input wire logic [`N_PINS-1:0]   gpio_oe_n_out,
   input wire logic [15:0]          port_irq_status_in,
   input wire logic [15:0]          porta_status_in,
   input wire logic [15:0]          portb_status_in,
   input wire logic [3:0]           porta_status_pick_in,
   input wire logic [3:0]           portb_status_pick_in,
   input wire logic                 ref8k_drive_in,
   input wire logic                 perf_update_req_out,
   input wire logic                 error_insert_req_out,
   input wire logic                 ref8k_in_out,
   input wire gpio_summary_pkg::ref_freq_t ref_freq_out,
   input wire logic                 int_n_out
);
   logic [15:0] sel_r;
   logic [15:0] ctl_r;
   logic [1:0]  en_r;
   logic [2:0]  quiet_r;
   logic        pa_r;
   logic        pb_r;
   logic        rk_r;
   logic [7:0]  drv;
   logic [7:0]  val;
   logic        ok;
   ref_freq_t   tbl [8];
   assign tbl = '{REF_44M736, REF_34M368, REF_51M84, REF_19M44, REF_77M76,
                  REF_UNDEFINED, REF_UNDEFINED, REF_UNDEFINED};
   // outputs lag a write by two edges and reset release by three
   assign ok = quiet_r >= 3'h3;
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sel_r <= 16'h0000;
         ctl_r <= 16'h0000;
         en_r <= 2'h0;
         quiet_r <= 3'h0;
      end
      else
      begin
         if (wr_in && addr_in == `OFF_PIN_FUNC_SEL)
            sel_r <= wr_data_in;
         if (wr_in && addr_in == `OFF_GLOBAL_CTRL)
            ctl_r <= wr_data_in & `CTRL_WMASK;
         if (wr_in && addr_in == `OFF_IRQ_SUM_ENABLE)
            en_r <= {wr_data_in[4], wr_data_in[0]};
         if (wr_in)
            quiet_r <= 3'h0;
         else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      pa_r <= porta_status_in[porta_status_pick_in];
      pb_r <= portb_status_in[portb_status_pick_in];
      rk_r <= ref8k_drive_in;
   end
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         drv[i] = sel_r[2*i+1] | (i < 2 && sel_r[2*i +: 2] == 2'h1);
         val[i] = sel_r[2*i];
      end
      val[0] = sel_r[1] ? sel_r[0] : pa_r;
      val[1] = sel_r[3] ? sel_r[2] : pb_r;
      if (ctl_r[5:4] == 2'h1)
         drv[7] = 1'b0;
      if (ctl_r[6])
         drv[5] = 1'b0;
      if (ctl_r[8])
         drv[3] = 1'b0;
      if (ctl_r[9])
      begin
         drv[1] = 1'b1;
         val[1] = rk_r;
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   AST_REF_FREQ: assert property (ok |->
         ref_freq_out == tbl[ctl_r[3:1]])
      else $error("adapter reference decode wrong");
   AST_PIN_OE: assert property (ok |->
         gpio_oe_n_out == ~drv)
      else $error("pin drive enable wrong");
   AST_PIN_VAL: assert property (ok |->
         ((gpio_out ^ val) & drv) == 8'h00)
      else $error("driven pin level wrong");
   AST_UPD_REQ: assert property (ok |-> perf_update_req_out ==
         (ctl_r[5:4] == 2'h1 && $past(gpio_in[7])))
      else $error("update request not from pin 8");
   AST_ERR_REQ: assert property (ok |-> error_insert_req_out ==
         (ctl_r[6] && $past(gpio_in[5])))
      else $error("error insert request not from pin 6");
   AST_REF8K_IN: assert property (ok |-> ref8k_in_out ==
         (ctl_r[8] && $past(gpio_in[3])))
      else $error("8 kHz reference not from pin 4");
   AST_INT_PORT: assert property (ok && en_r[1] &&
         |port_irq_status_in |=> !int_n_out)
      else $error("interrupt not raised by port summary");
   AST_INT_QUIET: assert property (ok && !en_r[0] &&
         !(en_r[1] && |port_irq_status_in) |=> int_n_out)
      else $error("interrupt active without enabled cause");
endmodule // gpio_summary_sva
bind global_gpio_and_interrupt_summary gpio_summary_sva chk
(
   .clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in),
   .addr_in(addr_in),
   .wr_data_in(wr_data_in),
   .wr_in(wr_in),
   .gpio_in(gpio_in),
   .gpio_out(gpio_out),
   .gpio_oe_n_out(gpio_oe_n_out),
   .port_irq_status_in(port_irq_status_in),
   .porta_status_in(porta_status_in),
   .portb_status_in(portb_status_in),
   .porta_status_pick_in(porta_status_pick_in),
   .portb_status_pick_in(portb_status_pick_in),
   .ref8k_drive_in(ref8k_drive_in),
   .perf_update_req_out(perf_update_req_out),
   .error_insert_req_out(error_insert_req_out),
   .ref8k_in_out(ref8k_in_out),
   .ref_freq_out(ref_freq_out),
   .int_n_out(int_n_out)
);
`default_nettype wire

//--- tb/board_pins.sv
// board side of the general-purpose pins, resolving each shared wire
`timescale 1ns/10ps
`default_nettype none
module board_pins
(
   input  wire logic [7:0] pin_drv_in,  // board level on released pins
   input  wire logic [7:0] dev_val_in,  // device drive value
   input  wire logic [7:0] dev_oe_n_in, // device enables, low drives
   output logic      [7:0] pin_out      // level seen on each wire
);
   // board pushes its level only where the device lets go
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pin_out[i] = dev_oe_n_in[i] ? pin_drv_in[i] : dev_val_in[i];
      end
   end
endmodule // board_pins
`default_nettype wire

//--- tb/global_gpio_and_interrupt_summary_tb.sv
// self-checking bench for the global pin and summary block
`timescale 1ns/10ps
`default_nettype none
`include "gpio_summary_map.svh"
`define CHK(got, want) \
   begin \
      comparisons++; \
      if ((got) !== (want)) \
      begin \
         n_errors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (want)); \
      end \
   end
module global_gpio_and_interrupt_summary_tb;
   import gpio_summary_pkg::*;
   logic clk, resetn, wr, rd, rk, upd_done, upd_en, upd_req, err_req;
   logic r8k, int_n, irq;
   logic [7:0]  addr, board, pins, gout, goe_n;
   logic [15:0] wdata, rdata, rdv, pirq, pa, pb;
   logic [3:0]  pick_a, pick_b;
   logic [1:0]  locked;
   ref_freq_t   rf;
   int          n_errors = 0, comparisons = 0;
   ref_freq_t   tbl [8] = '{REF_44M736, REF_34M368, REF_51M84, REF_19M44,
                  REF_77M76, REF_UNDEFINED, REF_UNDEFINED, REF_UNDEFINED};
   logic [7:0]  oe_t [4] = '{8'hff, 8'hfc, 8'h00, 8'h00};
   logic [7:0]  pin_t [4] = '{8'h5a, 8'h59, 8'h00, 8'hff};
   always #2.5 clk = ~clk;
   global_gpio_and_interrupt_summary dut
   (
      .clk_sys_in(clk), .resetn_in(resetn), .addr_in(addr),
      .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
      .gpio_in(pins), .gpio_out(gout), .gpio_oe_n_out(goe_n),
      .port_irq_status_in(pirq), .porta_status_in(pa),
      .portb_status_in(pb), .porta_status_pick_in(pick_a),
      .portb_status_pick_in(pick_b), .ref8k_drive_in(rk),
      .pll_locked_in(locked), .port_update_done_in(upd_done),
      .port_update_en_in(upd_en), .perf_update_req_out(upd_req),
      .error_insert_req_out(err_req), .ref8k_in_out(r8k),
      .ref_freq_out(rf), .int_n_out(int_n), .irq_out(irq)
   );
   board_pins board_i
   (
      .pin_drv_in(board), .dev_val_in(gout), .dev_oe_n_in(goe_n),
      .pin_out(pins)
   );
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rdv = rdata;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      `CHK(goe_n, 8'hff)
      rd_reg(`OFF_PIN_FUNC_SEL);
      `CHK(rdv, 16'h0000)
      rd_reg(`OFF_IRQ_SUM_ENABLE);
      `CHK(rdv, 16'h0000)
      rd_reg(8'h30);
      `CHK(rdv, 16'h0000)
   endtask
   task automatic t_ref();
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(`OFF_GLOBAL_CTRL, {12'h000, 3'(c), 1'b0});
         settle();
         `CHK(rf, tbl[c])
         rd_reg(`OFF_GLOBAL_CTRL);
         `CHK(rdv, {12'h000, 3'(c), 1'b0})
      end
   endtask
   task automatic t_pins();
      @(posedge clk);
      pa <= 16'h0020;
      pick_a <= 4'h5;
      pb <= 16'hfdff;
      pick_b <= 4'h9;
      board <= 8'h5a;
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(`OFF_PIN_FUNC_SEL, {8{2'(k)}});
         settle();
         `CHK(goe_n, oe_t[k])
         `CHK(pins, pin_t[k])
      end
   endtask
   task automatic t_override();
      wr_reg(`OFF_GLOBAL_CTRL, 16'h0350);
      @(posedge clk);
      board <= 8'h00;
      rk <= 1'b0;
      settle();
      `CHK(goe_n, 8'ha8)
      `CHK(pins, 8'h55)
      `CHK({upd_req, err_req, r8k}, 3'h0)
      @(posedge clk);
      board <= 8'ha8;
      rk <= 1'b1;
      settle();
      `CHK({upd_req, err_req, r8k}, 3'h7)
      `CHK(pins, 8'hff)
      wr_reg(`OFF_GLOBAL_CTRL, 16'h0020);
      settle();
      `CHK(goe_n, 8'h00)
      `CHK({upd_req, err_req, r8k}, 3'h0)
   endtask
   task automatic t_port_irq();
      wr_reg(`OFF_IRQ_SUM_ENABLE, 16'hffff);
      rd_reg(`OFF_IRQ_SUM_ENABLE);
      `CHK(rdv, 16'h0011)
      @(posedge clk);
      pirq <= 16'h8000;
      settle();
      `CHK(int_n, 1'b0)
      wr_reg(`OFF_IRQ_SUM_STATUS, 16'h0000);
      rd_reg(`OFF_IRQ_SUM_STATUS);
      `CHK(rdv[4], 1'b1)
      wr_reg(`OFF_IRQ_SUM_ENABLE, 16'h0001);
      settle();
      `CHK(int_n, 1'b1)
      @(posedge clk);
      pirq <= 16'h0000;
   endtask
   task automatic t_lock();
      wr_reg(`OFF_EVENT_MASK, 16'h0002);
      @(posedge clk);
      locked <= 2'h1;
      settle();
      rd_reg(`OFF_GLOBAL_LIVE);
      `CHK(rdv[1], 1'b1)
      `CHK({int_n, irq}, 2'h1)
      rd_reg(`OFF_IRQ_SUM_STATUS);
      `CHK(rdv[0], 1'b1)
      @(posedge clk);
      locked <= 2'h3;
      settle();
      rd_reg(`OFF_GLOBAL_LIVE);
      `CHK(rdv[1], 1'b0)
      `CHK(int_n, 1'b0)
      wr_reg(`OFF_EVENT_STATUS, 16'h0002);
      settle();
      `CHK({int_n, irq}, 2'h2)
   endtask
   task automatic t_update();
      logic [2:0] cs [3] = '{3'b100, 3'b111, 3'b001};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         upd_en <= cs[i][2];
         upd_done <= cs[i][1];
         settle();
         rd_reg(`OFF_GLOBAL_LIVE);
         `CHK(rdv[0], cs[i][0])
      end
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end
   initial
   begin
      {clk, resetn, wr, rd, rk, upd_done, upd_en} = '0;
      {addr, wdata, board, pirq, pa, pb, pick_a, pick_b} = '0;
      locked = 2'h3;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      settle();
      t_reset();
      t_ref();
      t_pins();
      t_override();
      t_port_irq();
      t_lock();
      t_update();
      conclude();
   end
endmodule // global_gpio_and_interrupt_summary_tb
`default_nettype wire
